/* smw_monitor.sv */
// supply monitor digital back end
// Notes on behaviour
// - first channel output selects filtered upper comparator or the window result
// - window result is lower comparator and not upper comparator
// - second output keeps showing lower comparator while window mode is used
// - filter enabled: comparator change reaches output after 64 us of stability
// - filter disabled: comparator result passes with a fixed 16 us delay
// - both filter paths sample in step with the logic clock
// - comparator status readable from the bus read port and the test port
// - measurement request routes the chosen input to converter and latches result
// - attenuator selects divide by three or straight through to converter
// - with attenuation set, the 10-bit code is tripled into 12 bits
// - readout splits into 8 upper and 4 lower bits, 2 mV per count
// - each macrocell is D-type, toggle-type or combinational bypass
// - macrocell async clear and preset from product term, global reset or power-up
// - digital inputs and comparators sampled by master clock, comparator filters by logic clock
// - free 8 MHz oscillator clocks comparators, filters, logic and timers except in slave mode; converter sequencing runs every REF_CLK cycle
// - clock mode standalone, master or slave sets the master clock pin
// - divide-by-32 prescaler makes 250 kHz for macrocells and timers
// - logic clock driven to its own pin while the output switch is closed
// - four timers, 128 codes each, 32 us to 1.96 s
// - macrocell ORs five product terms with polarity and xor control
`timescale 1ns/1ps
module smw_monitor #(
  parameter int unsigned TIMER_TICK_SHIFT = 0
) (
  input  wire logic                                          REF_CLK,
  input  wire logic                                          RST_N,
  input  wire logic                                          GLOBAL_RESET_N,
  input  wire smw_pkg::smw_clk_mode_type                     CLK_MODE,
  input  wire logic                                          MCLK_I,
  output logic                                               MCLK_O,
  output logic                                               MCLK_OE,
  input  wire logic                                          LOGIC_CLOCK_OUT_SWITCH,
  output logic                                               LOGIC_CLOCK_OUT_PIN,
  input  wire logic [smw_pkg::NUM_MON-1:0]                   UPPER_TRIP_COMPARATOR,
  input  wire logic [smw_pkg::NUM_MON-1:0]                   LOWER_TRIP_COMPARATOR,
  input  wire logic [smw_pkg::NUM_MON-1:0]                   WINDOW_MODE,
  input  wire logic [smw_pkg::NUM_MON-1:0]                   FILTER_EN,
  output logic [smw_pkg::NUM_MON-1:0]                        MON_A_OUT,
  output logic [smw_pkg::NUM_MON-1:0]                        MON_B_OUT,
  input  wire logic [smw_pkg::NUM_GP_IN-1:0]                 GP_IN,
  input  wire logic                                          MEAS_REQ,
  input  wire logic [smw_pkg::MON_SEL_W-1:0]                 MEAS_SEL,
  input  wire logic                                          MEAS_ATTEN,
  output logic [smw_pkg::MON_SEL_W-1:0]                      ADC_MUX_SEL,
  output logic                                               ADC_ATTEN_DIV3,
  output logic                                               ADC_START,
  input  wire logic                                          ADC_DONE,
  input  wire logic [smw_pkg::ADC_CODE_W-1:0]                ADC_CODE,
  output logic                                               MEAS_BUSY,
  input  wire logic [smw_pkg::REG_ADDR_W-1:0]                REG_RD_ADDR,
  output logic [7:0]                                         REG_RD_DATA,
  input  wire logic [smw_pkg::REG_ADDR_W-1:0]                TAP_RD_ADDR,
  output logic [7:0]                                         TAP_RD_DATA,
  input  wire smw_pkg::smw_mc_cfg_type [smw_pkg::NUM_MC-1:0] MC_CFG,
  input  wire smw_pkg::smw_mc_in_type  [smw_pkg::NUM_MC-1:0] MC_IN,
  output logic [smw_pkg::NUM_MC-1:0]                         MC_OUT,
  input  wire logic [smw_pkg::NUM_TIMER-1:0]                 TIMER_START,
  input  wire logic [smw_pkg::NUM_TIMER-1:0][smw_pkg::TIMER_CODE_W-1:0] TIMER_CODE,
  output logic [smw_pkg::NUM_TIMER-1:0]                      TIMER_EXPIRED
);

  localparam int unsigned NCMP = 2 * smw_pkg::NUM_MON;

  // clock generation
  logic [7:0]                  phase_q;
  logic [8:0]                  phase_sum;
  logic                        osc_tick;
  logic                        osc_level_q;
  logic                        mclk_in_q;
  logic                        mclk_prev_q;
  logic                        internal_osc_select_switch;
  logic                        clock_pin_link_switch;
  logic                        master_tick;
  logic [smw_pkg::PRESC_W-1:0] presc_q;
  logic                        logic_tick;
  logic                        logic_clk_pin_q;

  assign phase_sum = {1'b0, phase_q} + smw_pkg::PHASE_INC;
  assign osc_tick  = (phase_sum >= smw_pkg::PHASE_MOD);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      phase_q     <= smw_pkg::PHASE_RST;
      osc_level_q <= 1'b0;
    end
    else
    begin
      phase_q     <= osc_tick ? 8'(phase_sum - smw_pkg::PHASE_MOD) : phase_sum[7:0];
      osc_level_q <= (phase_q < smw_pkg::PHASE_HALF);
    end
  end

  assign internal_osc_select_switch = (CLK_MODE != smw_pkg::CLK_SLAVE);
  assign clock_pin_link_switch      = (CLK_MODE != smw_pkg::CLK_STANDALONE);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mclk_in_q   <= 1'b0;
      mclk_prev_q <= 1'b0;
    end
    else
    begin
      mclk_in_q   <= MCLK_I;
      mclk_prev_q <= mclk_in_q;
    end
  end

  assign master_tick = internal_osc_select_switch ? osc_tick :
                       (clock_pin_link_switch && mclk_in_q && !mclk_prev_q);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      MCLK_O <= 1'b0;
    else
      MCLK_O <= osc_level_q;
  end

  assign MCLK_OE = internal_osc_select_switch && clock_pin_link_switch;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      presc_q <= '0;
    else if (master_tick)
      presc_q <= presc_q + 5'h01;
  end

  assign logic_tick = master_tick && (presc_q == smw_pkg::PRESC_LAST);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      logic_clk_pin_q <= 1'b0;
    else
      logic_clk_pin_q <= LOGIC_CLOCK_OUT_SWITCH && presc_q[smw_pkg::PRESC_W-1];
  end

  assign LOGIC_CLOCK_OUT_PIN = logic_clk_pin_q;

  // comparator sampling and filters
  logic [NCMP-1:0]               cmp_raw_q;
  logic [NCMP-1:0]               cmp_filt;
  logic [NCMP-1:0]               cmp_en;
  logic [smw_pkg::NUM_GP_IN-1:0] gp_in_q;

  assign cmp_en = {FILTER_EN, FILTER_EN};

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cmp_raw_q <= '0;
      gp_in_q   <= '0;
    end
    else if (master_tick)
    begin
      cmp_raw_q <= {LOWER_TRIP_COMPARATOR, UPPER_TRIP_COMPARATOR};
      gp_in_q   <= GP_IN;
    end
  end

  for (genvar i = 0; i < NCMP; i++)
  begin : g_filt
    logic [smw_pkg::FILT_SHORT_TICKS-1:0] dly_q;
    logic [smw_pkg::FILT_CNT_W-1:0]       cnt_q;
    logic                                 stable_q;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
      if (!RST_N)
      begin
        dly_q    <= '0;
        cnt_q    <= '0;
        stable_q <= 1'b0;
      end
      else if (logic_tick)
      begin
        dly_q <= {dly_q[smw_pkg::FILT_SHORT_TICKS-2:0], cmp_raw_q[i]};
        if (cmp_raw_q[i] == stable_q)
          cnt_q <= '0;
        else if (cnt_q == smw_pkg::FILT_CNT_LAST)
        begin
          stable_q <= cmp_raw_q[i];
          cnt_q    <= '0;
        end
        else
          cnt_q <= cnt_q + 5'h01;
      end
    end

    assign cmp_filt[i] = cmp_en[i] ? stable_q : dly_q[smw_pkg::FILT_SHORT_TICKS-1];
  end

  logic [smw_pkg::NUM_MON-1:0] upper_f;
  logic [smw_pkg::NUM_MON-1:0] lower_f;

  assign upper_f = cmp_filt[smw_pkg::NUM_MON-1:0];
  assign lower_f = cmp_filt[NCMP-1:smw_pkg::NUM_MON];

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      MON_A_OUT <= '0;
      MON_B_OUT <= '0;
    end
    else
    begin
      MON_A_OUT <= (WINDOW_MODE & lower_f & ~upper_f) | (~WINDOW_MODE & upper_f);
      MON_B_OUT <= lower_f;
    end
  end

  // converter sequencing
  smw_pkg::smw_adc_state_type  adc_state_q;
  logic [smw_pkg::ADC_RES_W-1:0] adc_res_q;
  logic [smw_pkg::ADC_RES_W-1:0] adc_scaled;

  assign adc_scaled = ADC_ATTEN_DIV3 ?
    smw_pkg::ADC_RES_W'({2'b00, ADC_CODE} + {1'b0, ADC_CODE, 1'b0}) :
    smw_pkg::ADC_RES_W'(ADC_CODE);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      adc_state_q    <= smw_pkg::ADC_IDLE;
      adc_res_q      <= smw_pkg::ADC_RES_RST;
      ADC_MUX_SEL    <= '0;
      ADC_ATTEN_DIV3 <= 1'b0;
      ADC_START      <= 1'b0;
    end
    else
    begin
      case (adc_state_q)
        smw_pkg::ADC_IDLE:
        begin
          if (MEAS_REQ)
          begin
            ADC_MUX_SEL    <= MEAS_SEL;
            ADC_ATTEN_DIV3 <= MEAS_ATTEN;
            ADC_START      <= 1'b1;
            adc_state_q    <= smw_pkg::ADC_BUSY;
          end
        end
        smw_pkg::ADC_BUSY:
        begin
          ADC_START <= 1'b0;
          if (ADC_DONE && !ADC_START)
          begin
            adc_res_q   <= adc_scaled;
            adc_state_q <= smw_pkg::ADC_IDLE;
          end
        end
        default:
          adc_state_q <= smw_pkg::ADC_IDLE;
      endcase
    end
  end

  assign MEAS_BUSY = (adc_state_q == smw_pkg::ADC_BUSY);

  // readout ports
  smw_pkg::smw_status_type status;

  assign status = '{adc_res: adc_res_q, upper: upper_f, lower: lower_f,
                    busy: MEAS_BUSY, gp_in: gp_in_q};

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RD_DATA <= 8'h00;
      TAP_RD_DATA <= 8'h00;
    end
    else
    begin
      REG_RD_DATA <= smw_pkg::read_reg(REG_RD_ADDR, status);
      TAP_RD_DATA <= smw_pkg::read_reg(TAP_RD_ADDR, status);
    end
  end

  // macrocells
  for (genvar m = 0; m < smw_pkg::NUM_MC; m++)
  begin : g_mc
    logic sum;
    logic clr_n;
    logic set_n;
    logic mc_q;
    logic clr_hit;
    logic set_hit;

    assign sum = ((|MC_IN[m].pterm) ^ MC_CFG[m].invert) ^
                 (MC_CFG[m].xor_en & MC_IN[m].xor_in);

    always_comb
    begin
      case (MC_CFG[m].clr_src)
        smw_pkg::SRC_PTERM:  clr_hit = MC_IN[m].clr_pterm;
        smw_pkg::SRC_GLOBAL: clr_hit = !GLOBAL_RESET_N;
        smw_pkg::SRC_POR:    clr_hit = !RST_N;
        default:             clr_hit = 1'b0;
      endcase
      case (MC_CFG[m].set_src)
        smw_pkg::SRC_PTERM:  set_hit = MC_IN[m].set_pterm;
        smw_pkg::SRC_GLOBAL: set_hit = !GLOBAL_RESET_N;
        smw_pkg::SRC_POR:    set_hit = !RST_N;
        default:             set_hit = 1'b0;
      endcase
    end

    assign clr_n = !clr_hit && (RST_N || (MC_CFG[m].set_src == smw_pkg::SRC_POR));
    assign set_n = !set_hit;

    always_ff @(posedge REF_CLK or negedge clr_n or negedge set_n)
    begin
      if (!clr_n)
        mc_q <= 1'b0;
      else if (!set_n)
        mc_q <= 1'b1;
      else if (logic_tick)
      begin
        if (MC_CFG[m].mode == smw_pkg::MC_TTYPE)
          mc_q <= mc_q ^ sum;
        else
          mc_q <= sum;
      end
    end

    assign MC_OUT[m] = (MC_CFG[m].mode == smw_pkg::MC_COMB) ? sum : mc_q;
  end

  // timers
  for (genvar t = 0; t < smw_pkg::NUM_TIMER; t++)
  begin : g_tmr
    smw_timer #(
      .TICK_SHIFT (TIMER_TICK_SHIFT)
    ) u_timer (
      .clk     (REF_CLK),
      .rst_n   (RST_N),
      .tick    (logic_tick),
      .start   (TIMER_START[t]),
      .code    (TIMER_CODE[t]),
      .expired (TIMER_EXPIRED[t])
    );
  end

endmodule : smw_monitor

/* smw_pkg.sv */
// shared constants and types
package smw_pkg;

  localparam int unsigned REF_CLK_HZ      = 250_000_000;
  localparam int unsigned MASTER_CLK_HZ   = 8_000_000;
  localparam int unsigned PRESCALE_DIV    = 32;
  localparam int unsigned LOGIC_CLK_HZ    = MASTER_CLK_HZ / PRESCALE_DIV;
  localparam int unsigned LOGIC_PERIOD_NS = 1_000_000_000 / LOGIC_CLK_HZ;

  // oscillator phase accumulator, in MHz units
  localparam logic [8:0]  PHASE_INC  = 9'(MASTER_CLK_HZ / 1_000_000);
  localparam logic [8:0]  PHASE_MOD  = 9'(REF_CLK_HZ / 1_000_000);
  localparam logic [7:0]  PHASE_HALF = 8'(REF_CLK_HZ / 2_000_000);
  localparam logic [7:0]  PHASE_RST  = 8'h00;
  localparam int unsigned PRESC_W    = $clog2(PRESCALE_DIV);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE_DIV - 1);

  // comparator filter delays, counted in logic clock ticks
  localparam int unsigned FILT_LONG_US     = 64;
  localparam int unsigned FILT_SHORT_US    = 16;
  localparam int unsigned FILT_LONG_TICKS  =
    (FILT_LONG_US * 1000 + LOGIC_PERIOD_NS - 1) / LOGIC_PERIOD_NS;
  localparam int unsigned FILT_SHORT_TICKS =
    (FILT_SHORT_US * 1000 + LOGIC_PERIOD_NS - 1) / LOGIC_PERIOD_NS;
  localparam int unsigned FILT_CNT_W       = $clog2(FILT_LONG_TICKS + 1);
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_LAST = FILT_CNT_W'(FILT_LONG_TICKS - 1);

  localparam int unsigned NUM_MON    = 10;
  localparam int unsigned NUM_GP_IN  = 4;
  localparam int unsigned NUM_TIMER  = 4;
  localparam int unsigned NUM_MC     = 24;
  localparam int unsigned NUM_PT     = 5;
  localparam int unsigned MON_SEL_W  = 4;

  // timers: 128 codes, 32 us to 1.96 s in logic ticks
  localparam int unsigned TIMER_MIN_US = 32;
  localparam int unsigned TIMER_MAX_MS = 1960;
  localparam int unsigned TIMER_CODE_W = 7;
  localparam int unsigned TIMER_CNT_W  = 19;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP0 = 19'h00008;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP1 = 19'h00018;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP2 = 19'h00050;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP3 = 19'h000F0;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP4 = 19'h00320;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP5 = 19'h00960;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP6 = 19'h01F40;
  localparam logic [TIMER_CNT_W-1:0] TIMER_STEP7 = 19'h077A1;

  // converter and readout
  localparam int unsigned ADC_CODE_W = 10;
  localparam int unsigned ADC_RES_W  = 12;
  localparam int unsigned RES_UPPER_W = 8;
  localparam int unsigned RES_LOWER_W = 4;
  localparam logic [ADC_RES_W-1:0] ADC_RES_RST = 12'h000;
  localparam int unsigned RES_UV_PER_LSB = 2000;

  // readout register indices
  localparam int unsigned REG_ADDR_W = 4;
  localparam logic [REG_ADDR_W-1:0] REG_ADC_UPPER = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_ADC_LOWER = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_UP_LO     = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_UP_HI     = 4'h3;
  localparam logic [REG_ADDR_W-1:0] REG_LO_LO     = 4'h4;
  localparam logic [REG_ADDR_W-1:0] REG_LO_HI     = 4'h5;
  localparam logic [REG_ADDR_W-1:0] REG_MISC      = 4'h6;

  typedef enum logic [1:0] {
    CLK_STANDALONE = 2'b00,
    CLK_MASTER     = 2'b01,
    CLK_SLAVE      = 2'b10
  } smw_clk_mode_type;

  typedef enum logic [1:0] {
    MC_DTYPE = 2'b00,
    MC_TTYPE = 2'b01,
    MC_COMB  = 2'b10
  } smw_mc_mode_type;

  typedef enum logic [1:0] {
    SRC_NONE   = 2'b00,
    SRC_PTERM  = 2'b01,
    SRC_GLOBAL = 2'b10,
    SRC_POR    = 2'b11
  } smw_async_src_type;

  typedef enum logic {
    ADC_IDLE = 1'b0,
    ADC_BUSY = 1'b1
  } smw_adc_state_type;

  typedef struct packed {
    smw_mc_mode_type   mode;
    logic              invert;
    logic              xor_en;
    smw_async_src_type clr_src;
    smw_async_src_type set_src;
  } smw_mc_cfg_type;

  typedef struct packed {
    logic [NUM_PT-1:0] pterm;
    logic              xor_in;
    logic              clr_pterm;
    logic              set_pterm;
  } smw_mc_in_type;

  typedef struct packed {
    logic [ADC_RES_W-1:0] adc_res;
    logic [NUM_MON-1:0]   upper;
    logic [NUM_MON-1:0]   lower;
    logic                 busy;
    logic [NUM_GP_IN-1:0] gp_in;
  } smw_status_type;

  function automatic logic [TIMER_CNT_W-1:0] timer_ticks(input logic [TIMER_CODE_W-1:0] code);
    logic [TIMER_CNT_W-1:0] step;
    logic [TIMER_CNT_W-1:0] mult;
    case (code[6:4])
      3'h0:    step = TIMER_STEP0;
      3'h1:    step = TIMER_STEP1;
      3'h2:    step = TIMER_STEP2;
      3'h3:    step = TIMER_STEP3;
      3'h4:    step = TIMER_STEP4;
      3'h5:    step = TIMER_STEP5;
      3'h6:    step = TIMER_STEP6;
      default: step = TIMER_STEP7;
    endcase
    mult = TIMER_CNT_W'(code[3:0]) + 19'h00001;
    timer_ticks = TIMER_CNT_W'(step * mult);
  endfunction : timer_ticks

  function automatic logic [7:0] read_reg(input logic [REG_ADDR_W-1:0] idx,
                                          input smw_status_type s);
    if (idx == REG_ADC_UPPER)
      read_reg = s.adc_res[ADC_RES_W-1 -: RES_UPPER_W];
    else if (idx == REG_ADC_LOWER)
      read_reg = {4'h0, s.adc_res[RES_LOWER_W-1:0]};
    else if (idx == REG_UP_LO)
      read_reg = s.upper[7:0];
    else if (idx == REG_UP_HI)
      read_reg = {6'h00, s.upper[9:8]};
    else if (idx == REG_LO_LO)
      read_reg = s.lower[7:0];
    else if (idx == REG_LO_HI)
      read_reg = {6'h00, s.lower[9:8]};
    else if (idx == REG_MISC)
      read_reg = {s.gp_in, 3'h0, s.busy};
    else
      read_reg = 8'h00;
  endfunction : read_reg

endpackage : smw_pkg

/* smw_timer.sv */
// programmable timeout timer
`timescale 1ns/1ps
module smw_timer #(
  parameter int unsigned TICK_SHIFT = 0
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              tick,
  input  wire logic                              start,
  input  wire logic [smw_pkg::TIMER_CODE_W-1:0]  code,
  output logic                                   expired
);

  logic [smw_pkg::TIMER_CNT_W-1:0] cnt_q;
  logic [smw_pkg::TIMER_CNT_W-1:0] load_d;
  logic                            run_q;
  logic                            expired_q;

  always_comb
  begin
    load_d = smw_pkg::timer_ticks(code) >> TICK_SHIFT;
    if (load_d == '0)
      load_d = 19'h00001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q     <= '0;
      run_q     <= 1'b0;
      expired_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q     <= load_d;
      run_q     <= 1'b1;
      expired_q <= 1'b0;
    end
    else if (tick && run_q)
    begin
      if (cnt_q == 19'h00001)
      begin
        run_q     <= 1'b0;
        expired_q <= 1'b1;
      end
      cnt_q <= cnt_q - 19'h00001;
    end
  end

  assign expired = expired_q;

endmodule : smw_timer

/* smw_monitor_props.sv */
// assertion checker for the monitor top
`timescale 1ns/1ps
module smw_monitor_props (
  input logic       REF_CLK,
  input logic       RST_N,
  input logic [1:0] CLK_MODE,
  input logic       MCLK_O,
  input logic       MCLK_OE,
  input logic [9:0] WINDOW_MODE,
  input logic [9:0] MON_A_OUT,
  input logic [9:0] MON_B_OUT,
  input logic       MEAS_REQ,
  input logic [3:0] MEAS_SEL,
  input logic [3:0] ADC_MUX_SEL,
  input logic       ADC_START,
  input logic       ADC_DONE,
  input logic       MEAS_BUSY,
  input logic [3:0] REG_RD_ADDR,
  input logic [7:0] REG_RD_DATA,
  input logic [3:0] TIMER_START,
  input logic [3:0] TIMER_EXPIRED
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_req_idle;
    MEAS_REQ && !MEAS_BUSY;
  endsequence
  sequence s_launch;
    ADC_START && MEAS_BUSY ##1 !ADC_START;
  endsequence
  a_window_b_high: assert property ($stable(WINDOW_MODE) |->
    (MON_A_OUT & ~MON_B_OUT & WINDOW_MODE) == 10'h000) else $error("window without lower");
  a_req_launch: assert property (s_req_idle |=> s_launch)
    else $error("start strobe");
  a_mux_route: assert property (s_req_idle |=> ADC_MUX_SEL == $past(MEAS_SEL))
    else $error("mux select");
  a_busy_refuse: assert property (MEAS_BUSY && !ADC_DONE |=> !ADC_START)
    else $error("start while busy");
  a_busy_drop: assert property (MEAS_BUSY && ADC_DONE && !ADC_START |=> !MEAS_BUSY)
    else $error("busy after done");
  a_oe_mode: assert property (CLK_MODE != 2'h3 |->
    MCLK_OE == (CLK_MODE == smw_pkg::CLK_MASTER)) else $error("clock pin enable");
  a_mclk_period: assert property (disable iff (!RST_N || CLK_MODE != smw_pkg::CLK_MASTER)
    $rose(MCLK_O) |-> MCLK_O [*8] ##[20:26] $rose(MCLK_O)) else $error("master clock period");
  a_timer_clear: assert property (|TIMER_START |=>
    (TIMER_EXPIRED & $past(TIMER_START)) == 4'h0) else $error("expiry after start");
  a_expiry_hold: assert property (1'b1 |=>
    ($past(TIMER_EXPIRED) & ~$past(TIMER_START) & ~TIMER_EXPIRED) == 4'h0)
    else $error("expiry dropped");
  a_reg_unmapped: assert property (REG_RD_ADDR > smw_pkg::REG_MISC |=> REG_RD_DATA == 8'h00)
    else $error("unmapped read");
  a_reg_lower: assert property (REG_RD_ADDR == smw_pkg::REG_LO_LO |=>
    REG_RD_DATA == MON_B_OUT[7:0]) else $error("lower status read");
endmodule : smw_monitor_props
bind smw_monitor smw_monitor_props smw_monitor_props_i (
  .REF_CLK, .RST_N, .CLK_MODE, .MCLK_O, .MCLK_OE, .WINDOW_MODE, .MON_A_OUT, .MON_B_OUT,
  .MEAS_REQ, .MEAS_SEL, .ADC_MUX_SEL, .ADC_START, .ADC_DONE, .MEAS_BUSY, .REG_RD_ADDR,
  .REG_RD_DATA, .TIMER_START, .TIMER_EXPIRED
);

/* smw_adc_model.sv */
// converter model with set delay
`timescale 1ns/1ps
module smw_adc_model (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       start,
  input  logic [7:0] dly,
  input  logic [9:0] code_in,
  output logic       done,
  output logic [9:0] code
);
  logic [7:0] cnt_q;
  logic       run_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      done  <= 1'b0;
      code  <= 10'h000;
    end
    else
    begin
      done  <= run_q && cnt_q == 8'h00;
      run_q <= start || (run_q && cnt_q != 8'h00);
      cnt_q <= start ? dly : cnt_q - 8'h01;
      code  <= (run_q && cnt_q == 8'h00) ? code_in : ~code;
    end
  end
endmodule : smw_adc_model

/* smw_monitor_tb_top.sv */
// self-checking bench
`timescale 1ns/1ps
module smw_monitor_tb_top;
  typedef struct packed {
    logic        up;
    logic        lo;
    logic        win;
    logic [3:0]  sel;
    logic        att;
    logic [9:0]  code;
    logic        a;
    logic        b;
    logic [11:0] res;
  } smw_row_type;
  localparam smw_row_type ROWS [4] = '{
    '{1'b0, 1'b0, 1'b1, 4'h0, 1'b1, 10'h3FF, 1'b0, 1'b0, 12'hBFD},
    '{1'b0, 1'b1, 1'b1, 4'h9, 1'b0, 10'h155, 1'b1, 1'b1, 12'h155},
    '{1'b1, 1'b1, 1'b1, 4'h5, 1'b1, 10'h2AA, 1'b0, 1'b1, 12'h7FE},
    '{1'b1, 1'b0, 1'b0, 4'h3, 1'b1, 10'h000, 1'b1, 1'b0, 12'h000}};
  logic REF_CLK = 1'b0, RST_N = 1'b0, GLOBAL_RESET_N = 1'b1, MCLK_I = 1'b0, MCLK_O, MCLK_OE;
  logic SW = 1'b0, PIN, MEAS_REQ = 1'b0, ATT = 1'b0, DIV3, ADC_START, ADC_DONE, MEAS_BUSY;
  logic [9:0] UP = 10'h000, LO = 10'h000, WIN = 10'h000, FILT = 10'h000, MON_A, MON_B;
  logic [9:0] ADC_CODE, adc_code_in = 10'h000, prev;
  logic [3:0] GP_IN = 4'hA, SEL = 4'h0, MUX, RD_A = 4'h0, TAP_A = 4'h0, T_START = 4'h0, T_EXP;
  logic [7:0] RD_D, TAP_D, adc_dly = 8'h03;
  logic [3:0][6:0] T_CODE = '0;
  logic [23:0] MC_OUT;
  smw_pkg::smw_clk_mode_type CLK_MODE = smw_pkg::CLK_STANDALONE;
  smw_pkg::smw_mc_cfg_type [23:0] MC_CFG = '0;
  smw_pkg::smw_mc_in_type  [23:0] MC_IN = '0;
  int failures = 0, tests_run = 0, i, k;
  always #2 REF_CLK = ~REF_CLK;
  smw_monitor #(.TIMER_TICK_SHIFT(4)) smw_monitor_i (
    .REF_CLK, .RST_N, .GLOBAL_RESET_N, .CLK_MODE, .MCLK_I, .MCLK_O, .MCLK_OE,
    .LOGIC_CLOCK_OUT_SWITCH(SW), .LOGIC_CLOCK_OUT_PIN(PIN), .UPPER_TRIP_COMPARATOR(UP),
    .LOWER_TRIP_COMPARATOR(LO), .WINDOW_MODE(WIN), .FILTER_EN(FILT), .MON_A_OUT(MON_A),
    .MON_B_OUT(MON_B), .GP_IN, .MEAS_REQ, .MEAS_SEL(SEL), .MEAS_ATTEN(ATT), .ADC_MUX_SEL(MUX),
    .ADC_ATTEN_DIV3(DIV3), .ADC_START, .ADC_DONE, .ADC_CODE, .MEAS_BUSY, .REG_RD_ADDR(RD_A),
    .REG_RD_DATA(RD_D), .TAP_RD_ADDR(TAP_A), .TAP_RD_DATA(TAP_D), .MC_CFG, .MC_IN, .MC_OUT,
    .TIMER_START(T_START), .TIMER_CODE(T_CODE), .TIMER_EXPIRED(T_EXP));
  smw_adc_model smw_adc_model_i (.clk(REF_CLK), .rst_n(RST_N), .start(ADC_START),
    .dly(adc_dly), .code_in(adc_code_in), .done(ADC_DONE), .code(ADC_CODE));
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task bound(input int n, input int lim);
    if (n >= lim)
    begin
      failures++;
      finish_test;
    end
  endtask : bound
  task cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc
  task rdchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    @(negedge REF_CLK);
    RD_A = idx;
    TAP_A = idx;
    @(negedge REF_CLK);
    chk(what, 16'(RD_D), 16'(exp));
    chk(what, 16'(TAP_D), 16'(exp));
  endtask : rdchk
  task req(input logic [3:0] s, input logic a);
    @(negedge REF_CLK);
    SEL = s;
    ATT = a;
    MEAS_REQ = 1'b1;
    @(negedge REF_CLK);
    MEAS_REQ = 1'b0;
  endtask : req
  task wait_idle;
    for (k = 0; k < 300 && MEAS_BUSY !== 1'b0; k++) @(negedge REF_CLK);
    bound(k, 300);
  endtask : wait_idle
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST_N = 1'b1;
    chk("rst_exp", 16'(T_EXP), 16'h0000);
    chk("rst_busy", 16'(MEAS_BUSY), 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      prev = MON_B;
      UP = {10{ROWS[i].up}};
      LO = {10{ROWS[i].lo}};
      WIN = {10{ROWS[i].win}};
      adc_code_in = ROWS[i].code;
      req(ROWS[i].sel, ROWS[i].att);
      wait_idle;
      chk("mux_sel", 16'(MUX), 16'(ROWS[i].sel));
      chk("atten", 16'(DIV3), 16'(ROWS[i].att));
      rdchk("res_hi", smw_pkg::REG_ADC_UPPER, ROWS[i].res[11:4]);
      rdchk("res_lo", smw_pkg::REG_ADC_LOWER, {4'h0, ROWS[i].res[3:0]});
      cyc(2900);
      chk("mon_b_early", 16'(MON_B), 16'(prev));
      cyc(3100);
      chk("mon_a", 16'(MON_A), 16'({10{ROWS[i].a}}));
      chk("mon_b", 16'(MON_B), 16'({10{ROWS[i].b}}));
      rdchk("up_stat", smw_pkg::REG_UP_LO, {8{ROWS[i].up}});
      $display("test row %0d done", i);
    end
    FILT = 10'h3FF;
    LO = 10'h3FF;
    cyc(12000);
    chk("filt_early", 16'(MON_B), 16'h0000);
    for (k = 0; k < 9000 && MON_B !== 10'h3FF; k++) @(negedge REF_CLK);
    bound(k, 9000);
    chk("filt_late", 16'(MON_B), 16'h03FF);
    $display("test filter done");
    adc_dly = 8'h1E;
    req(4'h2, 1'b0);
    cyc(3);
    req(4'h7, 1'b1);
    chk("refused_sel", 16'(MUX), 16'h0002);
    chk("refused_att", 16'(DIV3), 16'h0000);
    wait_idle;
    rdchk("misc", smw_pkg::REG_MISC, 8'hA0);
    rdchk("unmapped", 4'hF, 8'h00);
    $display("test readout done");
    for (i = 0; i < 3; i++)
    begin
      @(negedge REF_CLK);
      CLK_MODE = smw_pkg::smw_clk_mode_type'(i);
      cyc(100);
      chk("clk_oe", 16'(MCLK_OE), 16'(i == 1));
    end
    CLK_MODE = smw_pkg::CLK_STANDALONE;
    SW = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      for (k = 0; k < 1100 && PIN !== (i != 1); k++) @(negedge REF_CLK);
      bound(k, 1100);
    end
    for (k = 0; k < 600 && PIN === 1'b1; k++) @(negedge REF_CLK);
    chk("pin_half", 16'(k >= 490 && k <= 510), 16'h0001);
    SW = 1'b0;
    cyc(2);
    chk("pin_open", 16'(PIN), 16'h0000);
    $display("test clocks done");
    T_CODE = {7'h00, 7'h00, 7'h00, 7'h03};
    T_START = 4'hF;
    cyc(1);
    T_START = 4'h0;
    cyc(900);
    chk("t0_early", 16'(T_EXP[0]), 16'h0000);
    for (k = 0; k < 2200 && T_EXP !== 4'hF; k++) @(negedge REF_CLK);
    bound(k, 2200);
    cyc(500);
    chk("t_hold", 16'(T_EXP), 16'h000F);
    T_START = 4'h1;
    cyc(1);
    T_START = 4'h0;
    chk("t_restart", 16'(T_EXP), 16'h000E);
    $display("test timers done");
    MC_CFG[1].mode = smw_pkg::MC_COMB;
    MC_CFG[1].invert = 1'b1;
    MC_CFG[0].clr_src = smw_pkg::SRC_GLOBAL;
    MC_IN[0].pterm[2] = 1'b1;
    cyc(1);
    chk("mc_comb", 16'(MC_OUT[1]), 16'h0001);
    MC_IN[1].pterm[4] = 1'b1;
    cyc(1100);
    chk("mc_comb_pt", 16'(MC_OUT[1]), 16'h0000);
    chk("mc_dff", 16'(MC_OUT[0]), 16'h0001);
    GLOBAL_RESET_N = 1'b0;
    #1;
    chk("mc_clr", 16'(MC_OUT[0]), 16'h0000);
    GLOBAL_RESET_N = 1'b1;
    $display("test macrocells done");
    finish_test;
  end
endmodule : smw_monitor_tb_top
